// [bench/test_logic_cell_data34_input_select.sv]
// Self-checking bench for the data line 3 and 4 source selection stage
`timescale 1ns/100ps
module test_logic_cell_data34_input_select
    import lcdis_pkg::*;
;
    //======================================================================
    // Stimulus and observed signals
    logic              clk;
    logic              reset;
    logic [7:0]        addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
    logic [7:0]        rdata;
    logic [15:0]       sources;
    logic              l3_t, l3_n, l4_t, l4_n;
    logic [31:0]       seed;
    logic [7:0]        value;
    int                bad_count;
    int                checks;

    lcdis_top i_dut (
        .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SOURCES(sources), .LINE3_TRUE_FORM(l3_t),
        .LINE3_INV_FORM(l3_n), .LINE4_TRUE_FORM(l4_t), .LINE4_INV_FORM(l4_n)
    );

    //======================================================================
    // Clock from the package period
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // Repeatable pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected source index per line, from the code tables
    function automatic int idx4(input logic [2:0] c);
        return c[2] ? int'(c[1:0]) : 12 + int'(c[1:0]);
    endfunction
    function automatic int idx3(input logic [2:0] c);
        return 8 + int'(c);
    endfunction

    //======================================================================
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One-cycle write strobe, driven just after the edge
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // Back-to-back strobes: two writes, then a read right behind them
    task automatic bus_burst(input logic [7:0] d1, input logic [7:0] d2);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= SEL_OFFSET;
        wdata <= d1;
        @(posedge clk);
        wdata <= d2;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        #1;
        check(rdata, d2 & 8'h77);
        @(posedge clk);
        #1;
        check(rdata, 8'h00);
    endtask

    // Synchroniser plus output register: three edges
    task automatic check_lines(input logic [2:0] c3, input logic [2:0] c4);
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, l3_t}, {7'h00, sources[idx3(c3)]});
        check({7'h00, l3_n}, {7'h00, ~sources[idx3(c3)]});
        check({7'h00, l4_t}, {7'h00, sources[idx4(c4)]});
        check({7'h00, l4_n}, {7'h00, ~sources[idx4(c4)]});
    endtask

    //======================================================================
    // Main sequence
    initial begin
        clk = 1'b0; reset = 1'b1; addr = 8'h00; wdata = 8'h00;
        wr = 1'b0; rd = 1'b0; sources = 16'h0000;
        seed = 32'h7466; bad_count = 0; checks = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        // Every code pair, with random filler in the unbuilt bits
        for (int i = 0; i < 64; i++) begin
            seed = lfsr(seed);
            bus_write(SEL_OFFSET, {seed[7], 3'(i >> 3), seed[3], 3'(i)});
            bus_read(SEL_OFFSET, value);
            check(value, {1'b0, 3'(i >> 3), 1'b0, 3'(i)});
            @(posedge clk);
            sources <= seed[23:8];
            check_lines(3'(i), 3'(i >> 3));
        end
        // All ones: unbuilt bits must read back as zero
        bus_write(SEL_OFFSET, 8'hFF);
        bus_read(SEL_OFFSET, value);
        check(value, 8'h77);
        // Writes elsewhere leave the register alone; reads elsewhere give zero
        bus_write(8'h01, 8'h00);
        bus_read(8'h01, value);
        check(value, 8'h00);
        bus_read(SEL_OFFSET, value);
        check(value, 8'h77);
        // Write, write, read with no idle cycle between the strobes
        seed = lfsr(seed);
        bus_burst(seed[7:0], seed[15:8]);
        // Mid-run reset keeps both codes; forms and read data sit at rest
        bus_write(SEL_OFFSET, 8'h25);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(rdata, 8'h00);
        check({4'h0, l4_t, l4_n, l3_t, l3_n}, 8'h05);
        @(posedge clk);
        reset <= 1'b0;
        bus_read(SEL_OFFSET, value);
        check(value, 8'h25);
        @(posedge clk);
        sources <= 16'hA55A;
        check_lines(3'h5, 3'h2);
        test_done();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule // test_logic_cell_data34_input_select

// [rtl/lcdis_pick.sv]
// One data line source picker with registered true and inverted forms
`timescale 1ns/100ps
module lcdis_pick
    import lcdis_pkg::*;
#(
    parameter logic [3:0] BASE = 4'h0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Synchronised sources and code
    input  wire logic [SRC_N-1:0]  src,
    input  wire logic [CODE_W-1:0] code,
    // Line forms
    output logic                   true_r,
    output logic                   inv_r
);

    logic [3:0] idx;
    logic       true_nxt;
    logic       inv_nxt;

    //======================================================================
    // Index wraps mod 16, so one adder covers every code
    always_comb begin
        idx      = {1'b0, code} + BASE;
        true_nxt = src[idx];
        inv_nxt  = ~src[idx];
    end

    // Both forms from flops so they never skew apart
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            true_r <= TRUE_RESET;
            inv_r  <= ~TRUE_RESET;
        end else begin
            true_r <= true_nxt;
            inv_r  <= inv_nxt;
        end
    end

endmodule // lcdis_pick

// [rtl/lcdis_pkg.sv]
// Constants shared by the data line 3 and 4 source selection stage
//==========================================================================
//==========================================================================
package lcdis_pkg;

    //======================================================================
    // Bus and register map
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 8;
    localparam logic [7:0]  SEL_OFFSET   = 8'h00;
    localparam logic [7:0]  SEL_RD_MASK  = 8'h77;
    localparam logic [7:0]  RDATA_RESET  = 8'h00;

    //======================================================================
    // Field layout
    localparam int          CODE_W       = 3;
    localparam int          LINE4_LSB    = 4;
    localparam int          LINE3_LSB    = 0;

    //======================================================================
    // Source routing
    localparam int          SRC_N        = 16;
    localparam logic [3:0]  LINE3_BASE   = 4'h8;
    localparam logic [3:0]  LINE4_BASE   = 4'hC;
    localparam logic        TRUE_RESET   = 1'b0;

    //======================================================================
    // Clock
    localparam int          CLK_PERIOD_NS = 100;

endpackage : lcdis_pkg

// [rtl/lcdis_top.sv]
// Data line 3 and 4 source selection register and pickers
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
module lcdis_top
    import lcdis_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET,
    // Register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // Source inputs from other clock domains
    input  wire logic [SRC_N-1:0]  SOURCES,
    // Selected lines to the gate logic
    output logic                   LINE3_TRUE_FORM,
    output logic                   LINE3_INV_FORM,
    output logic                   LINE4_TRUE_FORM,
    output logic                   LINE4_INV_FORM
);

    //======================================================================
    // Declarations
    logic [SRC_N-1:0]  src_s1_r;
    logic [SRC_N-1:0]  src_s2_r;
    logic [CODE_W-1:0] line3_source_code_r;
    logic [CODE_W-1:0] line3_source_code_nxt;
    logic [CODE_W-1:0] line4_source_code_r;
    logic [CODE_W-1:0] line4_source_code_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] sel_view;
    logic              wr_hit;
    logic              rd_hit;

    //======================================================================
    // Source synchroniser, first stage feeds only the second
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            src_s1_r <= '0;
            src_s2_r <= '0;
        end else begin
            src_s1_r <= SOURCES;
            src_s2_r <= src_s1_r;
        end
    end

    //======================================================================
    // Selection register
    // Writes are shut out while reset is high so reset can never disturb
    // the codes; software must load them once after power-up.
    always_comb begin
        wr_hit                = WR && !RESET && (ADDR == SEL_OFFSET);
        line4_source_code_nxt = line4_source_code_r;
        line3_source_code_nxt = line3_source_code_r;
        if (wr_hit) begin
            line4_source_code_nxt = WDATA[LINE4_LSB +: CODE_W];
            line3_source_code_nxt = WDATA[LINE3_LSB +: CODE_W];
        end
    end

    // No reset term: codes start undefined and survive every reset
    always_ff @(posedge CLK) begin
        line4_source_code_r <= line4_source_code_nxt;
        line3_source_code_r <= line3_source_code_nxt;
    end

    //======================================================================
    // Read path, data stand only in the cycle after the strobe
    always_comb begin
        sel_view                       = '0;
        sel_view[LINE4_LSB +: CODE_W]  = line4_source_code_r;
        sel_view[LINE3_LSB +: CODE_W]  = line3_source_code_r;
        rd_hit                         = RD && (ADDR == SEL_OFFSET);
        rdata_nxt                      = rd_hit ? (sel_view & SEL_RD_MASK) : '0;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_r <= RDATA_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    //======================================================================
    // Line pickers; the base offset turns each code into its source
    lcdis_pick #(
        .BASE (LINE3_BASE)
    ) u_line3 (
        .clk    (CLK),
        .reset  (RESET),
        .src    (src_s2_r),
        .code   (line3_source_code_r),
        .true_r (LINE3_TRUE_FORM),
        .inv_r  (LINE3_INV_FORM)
    );

    lcdis_pick #(
        .BASE (LINE4_BASE)
    ) u_line4 (
        .clk    (CLK),
        .reset  (RESET),
        .src    (src_s2_r),
        .code   (line4_source_code_r),
        .true_r (LINE4_TRUE_FORM),
        .inv_r  (LINE4_INV_FORM)
    );

    //======================================================================
    // Checks
    // The codes have no reset, so the helpers below come up unknown and the
    // checks that lean on them stay quiet until software loads the codes
    // Helper copies of what the pickers saw one edge ago
    logic [SRC_N-1:0]    chk_src_q;
    logic [CODE_W-1:0]   chk_l3_q;
    logic [CODE_W-1:0]   chk_l4_q;
    logic [2*CODE_W-1:0] chk_keep_q;
    logic                chk_written_q;
    logic                chk_valid_q;

    always_ff @(posedge CLK) begin
        chk_src_q     <= src_s2_r;
        chk_l3_q      <= line3_source_code_r;
        chk_l4_q      <= line4_source_code_r;
        // Sticky OR: set by the first write, so no reset term is needed
        // and an unknown start value only lasts until then
        chk_written_q <= chk_written_q | wr_hit;
        chk_valid_q   <= chk_written_q;
        // Frozen while reset is high
        if (!RESET) begin
            chk_keep_q <= {line4_source_code_r, line3_source_code_r};
        end
    end

    default clocking cb @(posedge CLK);
    endclocking

    default disable iff (RESET);

    // Field writes land in the matching code bits
    chk_line4_write: assert property (
        $past(wr_hit) |-> line4_source_code_r == $past(WDATA[6:4]))
        else $error("line 4 code not taken from bits 6 to 4");

    chk_line3_write: assert property (
        $past(wr_hit) |-> line3_source_code_r == $past(WDATA[2:0]))
        else $error("line 3 code not taken from bits 2 to 0");

    // Readback pairs with the codes held at the strobe
    chk_read_back: assert property (
        rd_hit |=> RDATA == {1'b0, $past(line4_source_code_r),
                             1'b0, $past(line3_source_code_r)})
        else $error("readback does not match held codes");

    chk_unbuilt_bits: assert property (
        $past(RD) |-> (RDATA[7] == 1'b0) && (RDATA[3] == 1'b0))
        else $error("unbuilt bits read non zero");

    chk_line4_low: assert property (
        !$past(RESET) && chk_l4_q[2]
        |-> LINE4_TRUE_FORM == chk_src_q[{2'b00, chk_l4_q[1:0]}])
        else $error("line 4 codes 100 to 111 misrouted");

    chk_line4_high: assert property (
        !$past(RESET) && !chk_l4_q[2]
        |-> LINE4_TRUE_FORM == chk_src_q[{2'b11, chk_l4_q[1:0]}])
        else $error("line 4 codes 000 to 011 misrouted");

    chk_line3_upper: assert property (
        !$past(RESET) && (chk_l3_q[2:1] != 2'b00)
        |-> LINE3_TRUE_FORM == chk_src_q[4'({1'b0, chk_l3_q}) + 4'h8])
        else $error("line 3 codes 010 to 111 misrouted");

    chk_line3_lower: assert property (
        !$past(RESET) && (chk_l3_q[2:1] == 2'b00)
        |-> LINE3_TRUE_FORM == chk_src_q[{3'b100, chk_l3_q[0]}])
        else $error("line 3 codes 000 and 001 misrouted");

    // Forms carry no meaning until the codes have been loaded once
    chk_both_forms: assert property (
        chk_valid_q
        |-> (LINE3_INV_FORM == !LINE3_TRUE_FORM) && (LINE4_INV_FORM == !LINE4_TRUE_FORM))
        else $error("inverted form not the complement");

    // Inverted forms follow the chosen source on their own flop
    chk_line3_inverse: assert property (
        chk_valid_q && !$past(RESET)
        |-> LINE3_INV_FORM == !chk_src_q[{1'b1, chk_l3_q}])
        else $error("line 3 inverted form misrouted");

    chk_line4_inverse: assert property (
        chk_valid_q && !$past(RESET)
        |-> LINE4_INV_FORM == !chk_src_q[{{2{!chk_l4_q[2]}}, chk_l4_q[1:0]}])
        else $error("line 4 inverted form misrouted");

    chk_codes_hold: assert property (
        chk_written_q && !$past(wr_hit)
        |-> $stable(line3_source_code_r) && $stable(line4_source_code_r))
        else $error("codes changed without a write");

    // Writes to any other offset are refused
    chk_wr_refused: assert property (
        chk_written_q && $past(WR && (ADDR != SEL_OFFSET))
        |-> $stable(line3_source_code_r) && $stable(line4_source_code_r))
        else $error("write to another offset changed the codes");

    // Compared with the copy frozen during reset, since a stability test
    // after release alone would miss codes cleared by the reset
    chk_reset_keeps: assert property (
        chk_written_q && $fell(RESET)
        |-> {line4_source_code_r, line3_source_code_r} == chk_keep_q)
        else $error("reset disturbed the codes");

    // Read data must not linger past the cycle after the strobe
    chk_rdata_idle: assert property (
        !$past(rd_hit) |-> RDATA == '0)
        else $error("read data present without a read");

    // Main scenarios
    cov_write_then_read: cover property (wr_hit ##1 rd_hit);
    cov_reset_keeps: cover property (chk_written_q && $fell(RESET));
    cov_line4_wrap: cover property (line4_source_code_r == 3'h3 ##1 line4_source_code_r == 3'h4);
    cov_line3_low: cover property (line3_source_code_r == 3'h0 && LINE3_TRUE_FORM);
    cov_back_to_back: cover property (wr_hit ##1 wr_hit);

endmodule // lcdis_top
